// ---- bench/eeprom_blk_seq_test.sv ----
`timescale 1ns/100ps
module eeprom_blk_seq_test;
   import eeprom_pkg::*;
   typedef struct packed {logic rdn; logic fast; logic [15:0] blk; status_t code;} row_t;
   // Ordinary cases: direction, rate, block, final status
   localparam row_t ROWS [4] = '{'{1'b0, 1'b1, 16'h0003, ST_TX_DONE},
      '{1'b1, 1'b1, 16'h0003, ST_RX_DONE}, '{1'b1, 1'b1, 16'h2000, ST_PARA_ERR},
      '{1'b0, 1'b1, 16'h1FFF, ST_TX_DONE}};
   logic        clk_sys_i, reset_i, rd, wr, nak, slv_oe;
   logic [7:0]  adr;
   logic [31:0] wdat, q, avs_readdata_o;
   logic        avs_waitrequest_o, scl_oe_o, sda_oe_o;
   wire logic   scl_w = ~scl_oe_o;
   wire logic   sda_w = ~(sda_oe_o | slv_oe);
   int          failures = 0;
   int          comparisons = 0;
   int          edges = 0;
   int          e0;
   time         t_last = 0;
   time         per = 0;
   eeprom_blk_seq #(.POLL_CYCLES(200)) dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .ce_i(1'b1), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe_o),
      .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe_o));
   eeprom_model #(.BUSY_POLLS(2)) partner (.scl_i(scl_w), .sda_i(sda_w), .nak_i(nak),
      .sda_oe_o(slv_oe));
   // Count SCL pulls and keep the spacing of the last two, one bit time
   always @(posedge scl_oe_o) begin
      edges++;
      per = $time - t_last;
      t_last = $time;
   end
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   function automatic logic [7:0] pat(input logic [15:0] b, input int i);
      return b[7:0] + 8'(8'h40 * i + 8'h15);
   endfunction : pat
   task automatic end_of_test();
      if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One bus cycle, held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      adr <= a;
      wr <= w;
      rd <= ~w;
      wdat <= d;
      // Values read just after the edge are the ones that edge sampled
      do begin
         @(posedge clk_sys_i);
      end while (avs_waitrequest_o !== 1'b0);
      r = avs_readdata_o;
      wr <= 1'b0;
      rd <= 1'b0;
      // One idle edge, so the next call never re-raises a strobe just lowered
      @(posedge clk_sys_i);
   endtask : bus
   // Start an access and poll status until it settles
   task automatic go(input logic r, input logic f);
      bus(1'b1, REG_CTRL, {29'h0, f, r, 1'b1}, q);
      // A hang is ended by the watchdog only
      do begin
         bus(1'b0, REG_STATUS, 32'h0, q);
      end while (q[8] !== 1'b0 || q[2:0] == ST_WRITING_AFTER_TRANSMIT);
   endtask : go
   initial begin
      repeat (98000) @(posedge clk_sys_i);
      failures++;
      end_of_test();
   end
   initial begin
      reset_i = 1'b1;
      {adr, rd, wr, wdat, nak} = '0;
      repeat (20) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      bus(1'b0, REG_STATUS, 32'h0, q);
      check(q, 32'h0);
      check({30'h0, scl_oe_o, sda_oe_o}, 32'h0);
      bus(1'b0, 8'hFC, 32'h0, q);
      check(q, 32'h0);
      for (int r = 0; r < 4; r++) begin
         e0 = edges;
         for (int i = 0; i < 4; i++)
            bus(1'b1, REG_DATA + 8'(4 * i), {24'h0, ROWS[r].rdn ? 8'h00 : pat(ROWS[r].blk, i)}, q);
         bus(1'b1, REG_BLOCK, {16'h0, ROWS[r].blk}, q);
         go(ROWS[r].rdn, ROWS[r].fast);
         check(q & 32'h107, {29'h0, ROWS[r].code});
         if (ROWS[r].code == ST_PARA_ERR) check(32'(edges - e0), 32'h0);
         // Bit time in ns: four quarters of 10 ns cycles
         if (ROWS[r].code != ST_PARA_ERR)
            check(32'(per), 32'(40 * (ROWS[r].fast ? QTR_FAST : QTR_STD)));
         if (ROWS[r].code == ST_RX_DONE) for (int i = 0; i < 4; i++) begin
            bus(1'b0, REG_DATA + 8'(4 * i), 32'h0, q);
            check(q, {24'h0, pat(ROWS[r].blk, i)});
         end
      end
      // Standard rate, memory refuses its address
      nak <= 1'b1;
      bus(1'b1, REG_BLOCK, 32'h0, q);
      go(1'b0, 1'b0);
      check(q & 32'h107, {29'h0, ST_NACK_ERR});
      check({30'h0, scl_oe_o, sda_oe_o}, 32'h0);
      check(32'(per), 32'(40 * QTR_STD));
      // Reset in mid-transfer must release the bus and clear the status
      bus(1'b1, REG_CTRL, 32'h1, q);
      repeat (1500) @(posedge clk_sys_i);
      reset_i <= 1'b1;
      @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      check({30'h0, scl_oe_o, sda_oe_o}, 32'h0);
      bus(1'b0, REG_STATUS, 32'h0, q);
      check(q, 32'h0);
      end_of_test();
   end
endmodule : eeprom_blk_seq_test

// ---- bench/eeprom_model.sv ----
`timescale 1ns/100ps
// Behavioural serial memory; acks its own address, stays busy for a few polls after a write
module eeprom_model
   import eeprom_pkg::*;
#(
   parameter int BUSY_POLLS = 2
) (
   // Bus lines and fault control
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic nak_i,
   output logic      sda_oe_o
);
   import eeprom_pkg::*;
   logic [7:0]  mem [logic [15:0]];
   logic [7:0]  sh_q;
   logic [15:0] ptr_q = 16'h0000;
   logic        act_q = 1'b0;
   logic        rd_q, ack_q;
   logic        wrote_q = 1'b0;
   logic        send_q = 1'b0;
   int          cnt_q, ph_q;
   int          busy_q = 0;
   initial sda_oe_o = 1'b0;
   // Start or repeated start; the falling clock that ends it is not a bit
   always @(negedge sda_i) if (scl_i) begin
      act_q = 1'b1;
      cnt_q = -1;
      ph_q = 0;
      send_q = 1'b0;
   end
   // Stop; programming starts only after a write reached the array
   always @(posedge sda_i) if (scl_i) begin
      act_q = 1'b0;
      if (wrote_q) busy_q = BUSY_POLLS;
      wrote_q = 1'b0;
   end
   // Sample data bits, or the master's answer after a sent byte
   always @(posedge scl_i) if (act_q) begin
      if (cnt_q < 8) sh_q = {sh_q[6:0], sda_i};
      else if (send_q && sda_i) send_q = 1'b0;
      else if (send_q) ptr_q++;
   end
   // Change the drive only while the clock is low
   always @(negedge scl_i) if (act_q) begin
      cnt_q++;
      sda_oe_o = 1'b0;
      if (cnt_q == 8 && ph_q < 4) begin
         sda_oe_o = 1'b1;
         case (ph_q)
            0: begin
               rd_q = sh_q[0];
               sda_oe_o = sh_q[7:1] == SLAVE_ADR[7:1] && busy_q == 0 && !nak_i;
               if (busy_q > 0) busy_q--;
            end
            1: ptr_q[15:8] = sh_q;
            2: ptr_q[7:0] = sh_q;
            default: begin
               mem[ptr_q] = sh_q;
               ptr_q++;
               wrote_q = 1'b1;
            end
         endcase
         ack_q = sda_oe_o;
      end
      if (cnt_q == 9) begin
         cnt_q = 0;
         if (ph_q == 0 && !ack_q) act_q = 1'b0;
         else if (ph_q == 0 && rd_q) begin
            send_q = 1'b1;
            ph_q = 4;
         end else if (ph_q < 3) ph_q++;
      end
      if (act_q && send_q && cnt_q < 8) sda_oe_o = ~mem[ptr_q][7 - cnt_q];
   end
endmodule : eeprom_model

// ---- logic/block_buf.sv ----
`timescale 1ns/100ps
module block_buf #(
   parameter int DEPTH = 4,
   parameter int AW    = 2,
   parameter int DW    = 8
) (
   // Clock
   input wire logic clk_sys_i,
   input wire logic ce_i,
   // Access port
   buf_if.store     bp
);
   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] mem;
      logic [DW-1:0]            rd;
   } buf_t;
   buf_t q;
   buf_t d;

   // Read data always comes from a register, one cycle after the address
   always_comb begin
      d = q;
      d.rd = q.mem[bp.raddr];
      if (bp.we) begin
         d.mem[bp.waddr] = bp.wdata;
      end
   end

   // Contents carry no reset; software fills the buffer before a write
   always_ff @(posedge clk_sys_i) begin
      if (ce_i) begin
         q <= d;
      end
   end

   assign bp.rdata = q.rd;
endmodule : block_buf

// ---- logic/buf_if.sv ----
`timescale 1ns/100ps
// Port between the sequencer and its block buffer
interface buf_if #(
   parameter int AW = 2,
   parameter int DW = 8
);
   logic          we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport ctrl  (output we, output waddr, output wdata, output raddr, input rdata);
   modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : buf_if

// ---- logic/eeprom_blk_seq.sv ----
`timescale 1ns/100ps
// Functional notes
// R01: Idle request checks block number; out of range ends with parameter error, no bus.
// R02: Valid request sends start then slave address with write direction.
// R03: Not-acknowledged slave or cell address byte gives stop and ends access.
// R04: Cell address is two bytes from 32K bits up, one byte up to 16K.
// R05: Read: after cell address ack, repeated start and slave address with read direction.
// R06: Read address acked: channel switches to receive and a dummy byte starts reception.
// R07: Each received byte is stored; with two or more left, next byte is acknowledged.
// R08: With one byte left, acknowledge output is disabled so the last byte gets nack.
// R09: After last byte is stored, channel stops, stop condition ends the read.
// R10: Write: after cell address ack, first data byte is loaded and sent.
// R11: Acked data byte sends the next; nacked data byte gives stop and ends.
// R12: No data left: stop condition lets the memory start programming.
// R13: After that stop a periodic 100 us timer paces completion polling.
// R14: Status becomes writing after transmit, where a nack is no error.
// R15: Each timer event then sends start and slave address with write direction. Code skips events that land while a poll is on the wire.
// R16: Nacked polling address: nothing else happens, wait for the next event.
// R17: Acked polling address: stop condition, channel and timer halted.
// R18: Acked polling sets status to transmission complete.
// R19: Bus rate about 384 kbps with fast option, else about 100 kbps.
// R20: Reset returns to idle, channel and timer stopped, bus released, status clear.
module eeprom_blk_seq
   import eeprom_pkg::*;
#(
   parameter int MEM_KBITS_P = eeprom_pkg::MEM_KBITS,
   parameter int POLL_CYCLES = eeprom_pkg::POLL_CYC
) (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   input  wire logic        ce_i,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // I2C pins, open drain
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe_o,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o
);
   import eeprom_pkg::*;

   localparam int  AW      = $clog2(BLK_SIZE);
   localparam int  IW      = $clog2(BLK_SIZE + 1);
   localparam int  TW      = 20;
   localparam int  BLOCKS  = MEM_KBITS_P * 128 / BLK_SIZE;
   localparam bit  TWO_ADR = (MEM_KBITS_P >= TWO_BYTE_KBITS);
   localparam logic [IW-1:0] IDX_END  = IW'(BLK_SIZE);
   localparam logic [IW-1:0] IDX_LAST = IW'(BLK_SIZE - 1);

   typedef struct packed {
      state_t        state;
      step_t         step;
      status_t       status;
      logic [7:0]    div;
      logic [1:0]    qph;
      logic [3:0]    bitn;
      logic [8:0]    sh;       // shift_data_register plus acknowledge bit
      logic          ack_oe;   // ack_output_enable
      logic [IW-1:0] idx;
      logic [15:0]   addr;
      logic          rd;
      logic          fast;
      logic [15:0]   block;
      logic          go;
      logic          poll_run; // poll_interval_timer running
      logic [TW-1:0] tmr;
      logic          scl_oe;
      logic          sda_oe;
      logic          scl_lvl;
      logic          sda_lvl;
      logic          scl_m;
      logic          scl_s;
      logic          sda_m;
      logic          sda_s;
      logic          waitreq;
      logic          ph;
      logic [31:0]   rdata;
      logic          mem_we;
      logic [AW-1:0] mem_waddr;
      logic [7:0]    mem_wdata;
   } st_t;

   st_t q;
   st_t d;

   buf_if #(.AW(AW), .DW(8)) bus_buf ();

   block_buf #(.DEPTH(BLK_SIZE), .AW(AW), .DW(8)) u_buf (
      .clk_sys_i (clk_sys_i),
      .ce_i      (ce_i),
      .bp        (bus_buf.store)
   );

   // Data window hit and slot, decoded for reads and writes alike
   function automatic logic data_hit(input logic [7:0] a);
      data_hit = (a >= REG_DATA) && (a < 8'(REG_DATA + 4 * BLK_SIZE));
   endfunction : data_hit

   function automatic logic [AW-1:0] data_slot(input logic [7:0] a);
      logic [7:0] off;
      off = a - REG_DATA;
      data_slot = off[AW+1:2];
   endfunction : data_slot

   // Small parts put the upper cell address bits into the slave address
   function automatic logic [7:0] sla_byte(input logic [15:0] a, input logic rd);
      sla_byte = TWO_ADR ? {SLAVE_ADR[7:1], rd} : {SLAVE_ADR[7:4], a[10:8], rd};
   endfunction : sla_byte

   logic       bus_req;
   logic       dat_ok;
   logic       tick;
   logic       done;
   logic       nack;
   logic [7:0] qtr;

   assign bus_req = avs_read_i | avs_write_i;
   // The buffer is shared, so the data window stalls while a transfer runs
   assign dat_ok  = !data_hit(avs_address_i) || (q.state == S_IDLE);
   // Quarter length follows the rate latched at start [R19]
   assign qtr     = q.fast ? 8'(QTR_FAST - 1) : 8'(QTR_STD - 1);
   // Phase 2 waits for SCL to read high, so a stretching slave is honoured
   assign tick    = (q.state inside {S_START, S_XFER, S_STOP}) && (q.div == 8'h00)
                    && !(q.qph == 2'h2 && !q.scl_s);
   assign done    = tick && (q.state == S_XFER) && (q.qph == 2'h3) && (q.bitn == 4'h8);
   assign nack    = q.sh[0];

   // Buffer port: bus owns the read address while idle
   assign bus_buf.raddr = (q.state == S_IDLE) ? data_slot(avs_address_i) : q.idx[AW-1:0];
   assign bus_buf.we    = q.mem_we;
   assign bus_buf.waddr = q.mem_waddr;
   assign bus_buf.wdata = q.mem_wdata;

   always_comb begin
      d = q;
      d.mem_we = 1'b0;
      d.go = 1'b0;
      d.scl_m = scl_i;
      d.scl_s = q.scl_m;
      d.sda_m = sda_i;
      d.sda_s = q.sda_m;

      // Bus slave: two-cycle answer, write takes effect as waitrequest is seen low
      if (!q.waitreq) begin
         d.waitreq = 1'b1;
         d.ph = 1'b0;
         if (avs_write_i && avs_byteenable_i[0]) begin
            if (avs_address_i == REG_CTRL && q.state == S_IDLE) begin
               d.go = avs_writedata_i[CTRL_GO_BIT];
               d.rd = avs_writedata_i[CTRL_READ_BIT];
               d.fast = avs_writedata_i[CTRL_FAST_BIT];
            end
            if (avs_address_i == REG_BLOCK && q.state == S_IDLE) begin
               d.block[7:0] = avs_writedata_i[7:0];
            end
            if (data_hit(avs_address_i)) begin
               d.mem_we = 1'b1;
               d.mem_waddr = data_slot(avs_address_i);
               d.mem_wdata = avs_writedata_i[7:0];
            end
         end
         if (avs_write_i && avs_byteenable_i[1] && avs_address_i == REG_BLOCK
             && q.state == S_IDLE) begin
            d.block[15:8] = avs_writedata_i[15:8];
         end
      end else if (bus_req && dat_ok) begin
         d.ph = 1'b1;
         if (q.ph) begin
            d.waitreq = 1'b0;
            d.rdata = UNMAPPED_VAL;
            if (avs_address_i == REG_CTRL) begin
               d.rdata = {29'h0, q.fast, q.rd, 1'b0};
            end else if (avs_address_i == REG_BLOCK) begin
               d.rdata = {16'h0, q.block};
            end else if (avs_address_i == REG_STATUS) begin
               d.rdata = {23'h0, q.state != S_IDLE, 5'h0, q.status};
            end else if (data_hit(avs_address_i)) begin
               d.rdata = {24'h0, bus_buf.rdata};
            end
         end
      end

      // Quarter-phase divider
      if (q.div != 8'h00) begin
         d.div = q.div - 8'h01;
      end else if (tick) begin
         d.div = qtr;
         d.qph = q.qph + 2'h1;
      end

      // Interval timer runs freely until halted [R13]
      if (q.poll_run) begin
         d.tmr = (q.tmr == '0) ? TW'(POLL_CYCLES - 1) : q.tmr - TW'(1);
      end

      case (q.state)
         S_IDLE: begin
            if (q.go) begin
               if ({1'b0, q.block} >= 17'(BLOCKS)) begin
                  d.status = ST_PARA_ERR;                       // [R01]
               end else begin
                  d.state = S_START;                            // [R02]
                  d.step = B_SLA;
                  d.status = ST_BUSY;
                  d.addr = q.block * 16'(BLK_SIZE);
                  d.idx = '0;
                  d.qph = 2'h0;
                  d.div = qtr;
               end
            end
         end
         // Start works from an idle bus and as a repeated start alike
         S_START: begin
            if (tick) begin
               case (q.qph)
                  2'h0: d.sda_oe = 1'b0;
                  2'h1: d.scl_oe = 1'b0;
                  2'h2: d.sda_oe = 1'b1;
                  default: begin
                     d.scl_oe = 1'b1;
                     d.state = S_XFER;
                     d.bitn = 4'h0;
                     d.sh = {sla_byte(q.addr, q.step == B_RSLA), 1'b1}; // [R02] [R05] [R15]
                  end
               endcase
            end
         end
         // Eight data bits then the acknowledge bit, MSB first
         S_XFER: begin
            if (tick) begin
               case (q.qph)
                  2'h0: d.sda_oe = ~q.sh[8];
                  2'h1: d.scl_oe = 1'b0;
                  2'h2: d.sh = {q.sh[7:0], q.sda_s};
                  default: begin
                     d.scl_oe = 1'b1;
                     d.bitn = (q.bitn == 4'h8) ? 4'h0 : q.bitn + 4'h1;
                  end
               endcase
            end
            if (done) begin
               case (q.step)
                  B_SLA, B_AHI, B_ALO, B_RSLA, B_WDAT: begin
                     if (nack) begin
                        d.state = S_STOP;                       // [R03] [R11]
                        d.status = ST_NACK_ERR;
                     end else if (q.step == B_SLA) begin
                        d.step = TWO_ADR ? B_AHI : B_ALO;       // [R04]
                        d.sh = {TWO_ADR ? q.addr[15:8] : q.addr[7:0], 1'b1};
                     end else if (q.step == B_AHI) begin
                        d.step = B_ALO;                         // [R04]
                        d.sh = {q.addr[7:0], 1'b1};
                     end else if (q.step == B_ALO && q.rd) begin
                        d.state = S_START;                      // [R05]
                        d.step = B_RSLA;
                     end else if (q.step == B_RSLA) begin
                        d.step = B_RDAT;                        // [R06]
                        d.ack_oe = (BLK_SIZE >= 2);             // [R07] [R08]
                        d.sh = {RX_DUMMY, ~d.ack_oe};
                     end else if (q.idx == IDX_END) begin
                        d.state = S_STOP;                       // [R12]
                        d.status = ST_WRITING_AFTER_TRANSMIT;   // [R14]
                     end else begin
                        d.step = B_WDAT;                        // [R10] [R11]
                        d.sh = {bus_buf.rdata, 1'b1};
                        d.idx = q.idx + IW'(1);
                     end
                  end
                  B_RDAT: begin
                     d.mem_we = 1'b1;                           // [R07]
                     d.mem_waddr = q.idx[AW-1:0];
                     d.mem_wdata = q.sh[8:1];
                     d.idx = q.idx + IW'(1);
                     if (q.idx == IDX_LAST) begin
                        d.state = S_STOP;                       // [R09]
                        d.status = ST_RX_DONE;
                     end else begin
                        d.ack_oe = (d.idx != IDX_LAST);         // [R07] [R08]
                        d.sh = {RX_DUMMY, ~d.ack_oe};
                     end
                  end
                  default: begin
                     if (nack) begin
                        d.state = S_PWAIT;                      // [R16]
                     end else begin
                        d.state = S_STOP;                       // [R17]
                        d.status = ST_TX_DONE;                  // [R18]
                        d.poll_run = 1'b0;
                     end
                  end
               endcase
            end
         end
         S_STOP: begin
            if (tick) begin
               case (q.qph)
                  2'h0: d.sda_oe = 1'b1;
                  2'h1: d.scl_oe = 1'b0;
                  2'h2: d.sda_oe = 1'b0;
                  default: begin
                     if (q.status == ST_WRITING_AFTER_TRANSMIT) begin
                        d.state = S_PWAIT;                      // [R13]
                        d.poll_run = 1'b1;
                        d.tmr = TW'(POLL_CYCLES - 1);
                     end else begin
                        d.state = S_IDLE;
                     end
                  end
               endcase
            end
         end
         // Events landing while a poll is on the wire are skipped
         S_PWAIT: begin
            if (q.tmr == '0) begin
               d.state = S_START;                               // [R15]
               d.step = B_POLL;
               d.qph = 2'h0;
               d.div = qtr;
            end
         end
         default: d.state = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         q <= '0;                                               // [R20]
         q.waitreq <= WAIT_RST;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign avs_readdata_o    = q.rdata;
   assign avs_waitrequest_o = q.waitreq;
   assign scl_o             = q.scl_lvl;
   assign scl_oe_o          = q.scl_oe;
   assign sda_o             = q.sda_lvl;
   assign sda_oe_o          = q.sda_oe;

   // Checks on the sequencer
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);

   sequence s_go_bad;
      q.state == S_IDLE && q.go && ({1'b0, q.block} >= 17'(BLOCKS)) && ce_i;
   endsequence
   sequence s_addr_byte_nack;
      done && nack && ce_i && (q.step inside {B_SLA, B_AHI, B_ALO});
   endsequence
   sequence s_poll_done;
      done && ce_i && q.step == B_POLL;
   endsequence
   sequence s_last_rx;
      done && ce_i && q.step == B_RDAT && q.idx == IDX_LAST;
   endsequence

   a_param_err_nobus: assert property (s_go_bad |=> q.status == ST_PARA_ERR
      && q.state == S_IDLE && !q.scl_oe) else $error("bad block not refused"); // [R01]
   a_start_edge: assert property ($rose(q.sda_oe) && !q.scl_oe |->
      q.state inside {S_START, S_STOP}) else $error("SDA fell outside start or stop"); // [R02]
   a_nack_stops: assert property (s_addr_byte_nack |=> q.state == S_STOP
      && q.status == ST_NACK_ERR) else $error("address nack did not stop"); // [R03]
   a_addr_len: assert property (done && ce_i && !nack && q.step == B_SLA |=>
      q.step == (TWO_ADR ? B_AHI : B_ALO)) else $error("wrong address length"); // [R04]
   a_read_restart: assert property (done && ce_i && !nack && q.step == B_ALO && q.rd
      |=> q.state == S_START && q.step == B_RSLA) else $error("no restart"); // [R05]
   a_rx_dummy: assert property (done && ce_i && !nack && q.step == B_RSLA |=>
      q.sh[8:1] == RX_DUMMY && q.step == B_RDAT) else $error("no dummy load"); // [R06]
   a_rx_ack_oe: assert property (q.state == S_XFER && q.step == B_RDAT |->
      q.ack_oe == (q.idx != IDX_LAST)) else $error("ack enable wrong"); // [R07] [R08]
   a_rx_finish: assert property (s_last_rx |=> q.state == S_STOP
      && q.status == ST_RX_DONE) else $error("read did not finish"); // [R09]
   a_poll_start: assert property (q.state == S_STOP && q.status == ST_WRITING_AFTER_TRANSMIT
      && tick && ce_i && q.qph == 2'h3 |=> q.state == S_PWAIT && q.poll_run
      && q.tmr == TW'(POLL_CYCLES - 1)) else $error("poll timer not started"); // [R13] [R14]
   a_poll_event: assert property (q.state == S_PWAIT && q.tmr == '0 && ce_i |=>
      q.state == S_START && q.step == B_POLL) else $error("poll not sent"); // [R15]
   a_poll_result: assert property (s_poll_done |=> (q.state == S_STOP
      && q.status == ST_TX_DONE && !q.poll_run) || (q.state == S_PWAIT && q.poll_run))
      else $error("poll answer mishandled"); // [R16] [R17] [R18]
   a_bus_answer: assert property (bus_req && dat_ok && q.waitreq && !q.ph && ce_i
      ##1 ce_i |=> !q.waitreq) else $error("bus answer late");
endmodule : eeprom_blk_seq

// ---- logic/eeprom_pkg.sv ----
package eeprom_pkg;
   // System clock
   localparam int CLK_KHZ   = 100000;
   localparam int CLK_MHZ   = 100;
   // Bus rates; one bit is four quarter phases, rounded up so the rate never exceeds the figure
   localparam int STD_KBPS  = 100;
   localparam int FAST_KBPS = 384;
   localparam int QTR_STD   = (CLK_KHZ + 4 * STD_KBPS - 1) / (4 * STD_KBPS);
   localparam int QTR_FAST  = (CLK_KHZ + 4 * FAST_KBPS - 1) / (4 * FAST_KBPS);
   // Completion polling period
   localparam int POLL_US   = 100;
   localparam int POLL_CYC  = POLL_US * CLK_MHZ;
   // Memory geometry
   localparam int MEM_KBITS      = 256;
   localparam int BLK_SIZE       = 4;
   localparam int TWO_BYTE_KBITS = 32;
   localparam logic [7:0] SLAVE_ADR = 8'hA0;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_BLOCK  = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_DATA   = 8'h10;
   // Field positions
   localparam int CTRL_GO_BIT   = 0;
   localparam int CTRL_READ_BIT = 1;
   localparam int CTRL_FAST_BIT = 2;
   localparam int STAT_BUSY_BIT = 8;
   // Reset value, unmapped read value and receive dummy byte
   localparam logic WAIT_RST  = 1'b1;
   localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
   localparam logic [7:0] RX_DUMMY = 8'hFF;

   typedef enum logic [2:0] {
      S_IDLE  = 3'h0,
      S_START = 3'h1,
      S_XFER  = 3'h2,
      S_STOP  = 3'h3,
      S_PWAIT = 3'h4
   } state_t;

   // Which byte is on the wire
   typedef enum logic [2:0] {
      B_SLA  = 3'h0,
      B_AHI  = 3'h1,
      B_ALO  = 3'h2,
      B_RSLA = 3'h3,
      B_RDAT = 3'h4,
      B_WDAT = 3'h5,
      B_POLL = 3'h6
   } step_t;

   typedef enum logic [2:0] {
      ST_CLEAR                  = 3'h0,
      ST_BUSY                   = 3'h1,
      ST_PARA_ERR               = 3'h2,
      ST_NACK_ERR               = 3'h3,
      ST_WRITING_AFTER_TRANSMIT = 3'h4,
      ST_TX_DONE                = 3'h5,
      ST_RX_DONE                = 3'h6
   } status_t;
endpackage : eeprom_pkg
